// ===== logic/srea_pkg.sv
// shared constants, states and contract of the smbus ram/eeprom access block
// Contract
// - write byte to 0x00-0xDF stores in ram
// - command 0xF8-0xFB plus one byte loads pointer
// - erase picks page from low byte bits 7:5; the code takes the page from pointer bits 9:5
// - two data bytes: address low, then program
// - acknowledge address, command and every data byte
// - command 0xFC: count, then count data bytes
// - hold scl low while a byte programs
// - receive byte returns one byte at pointer
// - block read: 0xFD, repeated start, read address
// - block read sends 0x20 then 32 bytes
// - optional check byte follows the last data
// - check byte follows block read data
// - check byte is crc-8, polynomial 0x07
// - send byte with ram address sets pointer
// - 0xFE erases only when config bit 2 set
// - nack every access while erase runs
// - slave address is 10011 plus two pins
package srea_pkg;
  // bus addressing and command codes
  localparam logic [4:0] SLV_ADDR_HI = 5'h13;
  localparam logic [7:0] RAM_TOP = 8'hDF;
  localparam logic [7:0] EE_HI_MIN = 8'hF8;
  localparam logic [7:0] EE_HI_MAX = 8'hFB;
  localparam logic [7:0] CMD_BLK_WR = 8'hFC;
  localparam logic [7:0] CMD_BLK_RD = 8'hFD;
  localparam logic [7:0] CMD_ERASE = 8'hFE;
  localparam logic [7:0] BLK_RD_COUNT = 8'h20;
  localparam logic [5:0] BLK_RD_LEN = 6'h20;
  localparam logic [5:0] PEC_IDX = 6'h21;
  // erase enable lives in a ram byte
  localparam logic [7:0] UPD_CFG_ADDR = 8'h90;
  localparam int UPD_ERASE_BIT = 2;
  localparam int RAM_DEPTH = 224;
  // eeprom offset and page field
  localparam int EE_OFS_W = 10;
  localparam int EE_PAGE_LSB = 5;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_PROG_US = 250;
  localparam int T_ERASE_MS = 20;
  localparam int PROG_CNT = (T_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CNT = (T_ERASE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 20;
  // byte engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_MACK = 6'h10,
    ST_WAIT = 6'h20
  } srea_state_e;
endpackage : srea_pkg

// ===== logic/srea_crc_if.sv
// bit-serial crc channel between the byte engine and the checker
`timescale 1ns/10ps
interface srea_crc_if;
  logic clr;
  logic en;
  logic din;
  logic [7:0] crc;
  modport calc (input clr, input en, input din, output crc);
  modport user (output clr, output en, output din, input crc);
endinterface : srea_crc_if

// ===== logic/srea_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module srea_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  // first stage feeds only the second; reset to the idle level of each line
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d_in;
      q_ff <= meta_ff;
    end
  end

  assign q_out = q_ff;
endmodule : srea_sync

// ===== logic/srea_crc8.sv
// bit-serial crc-8 over every transferred data bit
`timescale 1ns/10ps
module srea_crc8 import srea_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  srea_crc_if.calc crc_if
);
  logic [7:0] crc_ff;
  logic fb;

  assign fb = crc_ff[7] ^ crc_if.din;

  // msb-first shift, clear wins since it marks a new transaction
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_ff <= CRC_INIT;
    end else if (crc_if.clr) begin
      crc_ff <= CRC_INIT;
    end else if (crc_if.en) begin
      crc_ff <= {crc_ff[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
  end

  assign crc_if.crc = crc_ff;

  chk_crc_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    crc_if.clr |=> crc_ff == CRC_INIT) else $error("crc not cleared");
endmodule : srea_crc8

// ===== logic/srea_top.sv
// smbus slave command decoder for user ram and paged eeprom
`timescale 1ns/10ps
module srea_top import srea_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CNT,
  parameter int ERASE_CYCLES = ERASE_CNT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_select_hi_pin,
  input wire logic addr_select_lo_pin,
  input wire logic [7:0] ee_rdata,
  output logic [EE_OFS_W-1:0] ee_rd_addr,
  output logic ee_prog,
  output logic [EE_OFS_W-1:0] ee_prog_addr,
  output logic [7:0] ee_wdata,
  output logic ee_erase,
  output logic [EE_OFS_W-EE_PAGE_LSB-1:0] ee_erase_page,
  output logic busy
);
  // synchronised pins and their delayed copies
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic a_hi_s;
  logic a_lo_s;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // byte engine
  srea_state_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shreg_ff;
  logic [2:0] byte_idx_ff;
  logic rw_ff;
  logic mack_ff;
  logic [5:0] tx_idx_ff;

  // command, pointers and storage
  logic [7:0] cmd_ff;
  logic [7:0] ram_ptr_ff;
  logic [15:0] ee_ptr_ff;
  logic sel_ee_ff;
  logic [7:0] blk_left_ff;
  logic [7:0] ram_ff [RAM_DEPTH];
  logic [BUSY_W-1:0] prog_cnt_ff;
  logic [BUSY_W-1:0] erase_cnt_ff;

  // output flops
  logic scl_hold_ff;
  logic scl_oe_n_ff;
  logic sda_oe_n_ff;
  logic ee_prog_ff;
  logic [EE_OFS_W-1:0] ee_prog_addr_ff;
  logic [7:0] ee_wdata_ff;
  logic ee_erase_ff;
  logic [EE_OFS_W-EE_PAGE_LSB-1:0] ee_erase_page_ff;
  logic busy_ff;

  // decode terms
  logic prog_busy;
  logic erase_busy;
  logic rx_end;
  logic wait_need;
  logic byte_go;
  logic addr_hit;
  logic cmd_is_ram;
  logic cmd_is_ee;
  logic wr_byte;
  logic blk_wr_data;
  logic ram_we;
  logic [7:0] ram_wa;
  logic ee_we;
  logic ptr_load;
  logic erase_go;
  logic blk_rd;
  logic tx_data;
  logic tx_load;
  logic [7:0] rd_byte;
  logic [7:0] tx_byte;
  srea_state_e ack_or_idle;

  srea_crc_if crc_if ();

  // bus lines idle high, so they reset high: no false edge after reset
  srea_sync #(
    .WIDTH(4),
    .RST_VAL(4'hC)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .d_in({scl_in, sda_in, addr_select_hi_pin, addr_select_lo_pin}),
    .q_out(pins_s)
  );

  srea_crc8 u_crc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .crc_if(crc_if.calc)
  );

  assign {scl_s, sda_s, a_hi_s, a_lo_s} = pins_s;

  // edge history of the already synchronised lines
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // start and stop are sda moves while scl stays high
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  assign prog_busy = prog_cnt_ff != '0;
  assign erase_busy = erase_cnt_ff != '0;

  // byte completion; data bytes wait while a byte programs
  assign rx_end = (state_ff == ST_RX) && scl_fall && (bit_cnt_ff == 4'h8);
  assign wait_need = prog_busy && (byte_idx_ff != 3'h0);
  assign byte_go = (rx_end && !wait_need) || ((state_ff == ST_WAIT) && !prog_busy);
  assign addr_hit = shreg_ff[7:1] == {SLV_ADDR_HI, a_hi_s, a_lo_s};
  // address must match and no erase may run; data bytes always get an ack
  assign ack_or_idle = ((byte_idx_ff != 3'h0) || (addr_hit && !erase_busy)) ? ST_ACK : ST_IDLE;

  // command classes
  assign cmd_is_ram = cmd_ff <= RAM_TOP;
  assign cmd_is_ee = (cmd_ff >= EE_HI_MIN) && (cmd_ff <= EE_HI_MAX);
  assign wr_byte = byte_go && !rw_ff && (byte_idx_ff != 3'h0);
  // count bytes beyond the announced length are taken as the check byte
  assign blk_wr_data = wr_byte && (cmd_ff == CMD_BLK_WR) && (byte_idx_ff >= 3'h3)
    && (blk_left_ff != 8'h00);

  // memory write events
  assign ram_we = (wr_byte && (byte_idx_ff == 3'h2) && cmd_is_ram)
    || (blk_wr_data && !sel_ee_ff && (ram_ptr_ff <= RAM_TOP));
  assign ram_wa = (byte_idx_ff == 3'h2) ? cmd_ff : ram_ptr_ff;
  assign ee_we = (wr_byte && (byte_idx_ff == 3'h3) && cmd_is_ee)
    || (blk_wr_data && sel_ee_ff);
  assign ptr_load = wr_byte && (byte_idx_ff == 3'h2) && cmd_is_ee;
  assign erase_go = wr_byte && (byte_idx_ff == 3'h1) && (shreg_ff == CMD_ERASE)
    && ram_ff[UPD_CFG_ADDR][UPD_ERASE_BIT] && !erase_busy;

  // read path: count, data at the pointer, then the check byte
  assign blk_rd = cmd_ff == CMD_BLK_RD;
  assign tx_data = blk_rd ? ((tx_idx_ff != 6'h00) && (tx_idx_ff <= BLK_RD_LEN))
    : (tx_idx_ff == 6'h00);
  assign rd_byte = sel_ee_ff ? ee_rdata
    : ((ram_ptr_ff <= RAM_TOP) ? ram_ff[ram_ptr_ff] : 8'h00);
  assign tx_byte = (blk_rd && (tx_idx_ff == 6'h00)) ? BLK_RD_COUNT
    : (tx_data ? rd_byte : crc_if.crc);
  assign tx_load = scl_fall
    && (((state_ff == ST_ACK) && rw_ff) || ((state_ff == ST_MACK) && !mack_ff));

  // received bits enter the crc at the fall after them, so the rise ahead
  // of a repeated start never counts; sent bits enter on the rise
  assign crc_if.clr = bus_start && (state_ff == ST_IDLE);
  assign crc_if.en = (scl_fall && (state_ff == ST_RX) && (bit_cnt_ff != 4'h0))
    || (scl_rise && (state_ff == ST_TX));
  assign crc_if.din = (state_ff == ST_TX) ? shreg_ff[7] : shreg_ff[0];

  // byte engine; stop and start override any state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      byte_idx_ff <= 3'h0;
      rw_ff <= 1'b0;
      mack_ff <= 1'b1;
      tx_idx_ff <= 6'h00;
    end else if (bus_stop) begin
      state_ff <= ST_IDLE;
    end else if (bus_start) begin
      state_ff <= ST_RX;
      bit_cnt_ff <= 4'h0;
      byte_idx_ff <= 3'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          bit_cnt_ff <= 4'h0;
        end
        ST_RX: begin
          if (scl_rise && (bit_cnt_ff != 4'h8)) begin
            shreg_ff <= {shreg_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (rx_end) begin
            state_ff <= wait_need ? ST_WAIT : ack_or_idle;
          end
        end
        ST_WAIT: begin
          if (!prog_busy) begin
            state_ff <= ack_or_idle;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (byte_idx_ff != 3'h7) begin
              byte_idx_ff <= byte_idx_ff + 3'h1;
            end
            state_ff <= rw_ff ? ST_TX : ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            shreg_ff <= {shreg_ff[6:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7) begin
              state_ff <= ST_MACK;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_ff <= sda_s;
          end else if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            // a master nack ends the read
            state_ff <= mack_ff ? ST_IDLE : ST_TX;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      if (byte_go && (byte_idx_ff == 3'h0)) begin
        rw_ff <= shreg_ff[0];
        tx_idx_ff <= 6'h00;
      end
      if (tx_load) begin
        shreg_ff <= tx_byte;
        if (tx_idx_ff != 6'h3F) begin
          tx_idx_ff <= tx_idx_ff + 6'h01;
        end
      end
    end
  end

  // command, pointers and block counter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_ff <= 8'h00;
      ram_ptr_ff <= 8'h00;
      ee_ptr_ff <= {EE_HI_MIN, 8'h00};
      sel_ee_ff <= 1'b0;
      blk_left_ff <= 8'h00;
    end else begin
      if (wr_byte && (byte_idx_ff == 3'h1)) begin
        cmd_ff <= shreg_ff;
        if (shreg_ff <= RAM_TOP) begin
          ram_ptr_ff <= shreg_ff;
          sel_ee_ff <= 1'b0;
        end
      end
      if (ptr_load) begin
        ee_ptr_ff <= {cmd_ff, shreg_ff};
        sel_ee_ff <= 1'b1;
      end
      if (wr_byte && (byte_idx_ff == 3'h2) && (cmd_ff == CMD_BLK_WR)) begin
        blk_left_ff <= shreg_ff;
      end
      // block data steps the active pointer, reads and writes alike
      if (blk_wr_data || (tx_load && blk_rd && tx_data)) begin
        if (blk_wr_data) begin
          blk_left_ff <= blk_left_ff - 8'h01;
        end
        if (sel_ee_ff) begin
          ee_ptr_ff <= ee_ptr_ff + 16'h0001;
        end else begin
          ram_ptr_ff <= ram_ptr_ff + 8'h01;
        end
      end
    end
  end

  // user ram; cleared at reset so reads are defined
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        ram_ff[i] <= 8'h00;
      end
    end else if (ram_we) begin
      ram_ff[ram_wa] <= shreg_ff;
    end
  end

  // program and erase timers; a new program restarts its timer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_cnt_ff <= '0;
      erase_cnt_ff <= '0;
    end else begin
      if (ee_we) begin
        prog_cnt_ff <= BUSY_W'(PROG_CYCLES);
      end else if (prog_busy) begin
        prog_cnt_ff <= prog_cnt_ff - BUSY_W'(1);
      end
      if (erase_go) begin
        erase_cnt_ff <= BUSY_W'(ERASE_CYCLES);
      end else if (erase_busy) begin
        erase_cnt_ff <= erase_cnt_ff - BUSY_W'(1);
      end
    end
  end

  // eeprom array strobes; the low five bits never reach the erase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ee_prog_ff <= 1'b0;
      ee_prog_addr_ff <= '0;
      ee_wdata_ff <= 8'h00;
      ee_erase_ff <= 1'b0;
      ee_erase_page_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      ee_prog_ff <= ee_we;
      ee_erase_ff <= erase_go;
      busy_ff <= prog_busy | erase_busy;
      if (ee_we) begin
        ee_prog_addr_ff <= ee_ptr_ff[EE_OFS_W-1:0];
        ee_wdata_ff <= shreg_ff;
      end
      if (erase_go) begin
        ee_erase_page_ff <= ee_ptr_ff[EE_OFS_W-1:EE_PAGE_LSB];
      end
    end
  end

  // open-drain drivers; scl released one cycle after sda is set up
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_hold_ff <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
    end else begin
      scl_hold_ff <= state_ff == ST_WAIT;
      scl_oe_n_ff <= !((state_ff == ST_WAIT) || scl_hold_ff);
      sda_oe_n_ff <= !((state_ff == ST_ACK)
        || ((state_ff == ST_TX) && !shreg_ff[7]));
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = scl_oe_n_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign ee_rd_addr = ee_ptr_ff[EE_OFS_W-1:0];
  assign ee_prog = ee_prog_ff;
  assign ee_prog_addr = ee_prog_addr_ff;
  assign ee_wdata = ee_wdata_ff;
  assign ee_erase = ee_erase_ff;
  assign ee_erase_page = ee_erase_page_ff;
  assign busy = busy_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_ram_store: assert property (ram_we |=> ram_ff[$past(ram_wa)] == $past(shreg_ff))
    else $error("ram byte not stored");
  chk_ptr_load: assert property (ptr_load |=> sel_ee_ff
    && (ee_ptr_ff == {$past(cmd_ff), $past(shreg_ff)}))
    else $error("eeprom pointer not loaded");
  chk_erase_page: assert property (erase_go |=> ee_erase
    && (ee_erase_page == $past(ee_ptr_ff[EE_OFS_W-1:EE_PAGE_LSB])))
    else $error("wrong erase page");
  chk_ee_prog: assert property (ee_we |=> ee_prog && (ee_wdata == $past(shreg_ff))
    && (ee_prog_addr == $past(ee_ptr_ff[EE_OFS_W-1:0])) ##1 busy)
    else $error("eeprom byte not programmed");
  chk_data_ack: assert property (rx_end && (byte_idx_ff != 3'h0) && !wait_need
    |=> (state_ff == ST_ACK) ##1 !sda_oe_n_ff)
    else $error("data byte not acknowledged");
  chk_stretch_hold: assert property ((state_ff == ST_WAIT) |=> !scl_oe_n_ff)
    else $error("scl not held while programming");
  chk_count_byte: assert property (tx_load && blk_rd && (tx_idx_ff == 6'h00)
    |=> shreg_ff == BLK_RD_COUNT)
    else $error("block count byte wrong");
  chk_pec_load: assert property (tx_load && blk_rd && (tx_idx_ff == PEC_IDX)
    |=> shreg_ff == $past(crc_if.crc))
    else $error("check byte not sent after data");
  chk_erase_gate: assert property (ee_erase |-> $past(ram_ff[UPD_CFG_ADDR][UPD_ERASE_BIT]))
    else $error("erase without enable");
  chk_erase_nack: assert property (rx_end && (byte_idx_ff == 3'h0) && erase_busy
    |=> state_ff == ST_IDLE)
    else $error("access acked during erase");
  chk_addr_miss: assert property (rx_end && (byte_idx_ff == 3'h0) && !addr_hit
    |=> (state_ff == ST_IDLE) ##1 sda_oe_n_ff)
    else $error("foreign address acked");
  chk_blk_step: assert property (blk_wr_data && !sel_ee_ff
    |=> ram_ptr_ff == 8'($past(ram_ptr_ff) + 8'h01))
    else $error("ram pointer did not step");
endmodule : srea_top

// ===== test/srea_master.sv
// behavioural smbus master for the ram/eeprom access bench
`timescale 1ns/10ps
module srea_master (
  input wire logic ref_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  localparam int QTR = 50;
  // both lines released at power up; pull-ups make them idle high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // a stretching device releases scl on its own edge; realign to the
  // falling clock so our line changes stay off the sampling edge
  task automatic wait_scl_high;
    wait (scl === 1'b1);
    @(negedge ref_clk);
  endtask : wait_scl_high
  // waits on the wire, so a stretching device holds us back
  task automatic put_bit(input logic b);
    sda_low = ~b;
    #QTR scl_low = 1'b0;
    wait_scl_high();
    #(2 * QTR) scl_low = 1'b1;
    #QTR;
  endtask : put_bit
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #QTR scl_low = 1'b0;
    wait_scl_high();
    #QTR b = sda;
    #QTR scl_low = 1'b1;
    #QTR;
  endtask : get_bit
  // also serves as repeated start from a low clock
  task automatic bus_start;
    sda_low = 1'b0;
    #QTR scl_low = 1'b0;
    wait_scl_high();
    #QTR sda_low = 1'b1;
    #QTR scl_low = 1'b1;
    #QTR;
  endtask : bus_start
  // clock then stands still high until the next frame
  task automatic bus_stop;
    sda_low = 1'b1;
    #QTR scl_low = 1'b0;
    wait_scl_high();
    #QTR sda_low = 1'b0;
    #(2 * QTR);
  endtask : bus_stop
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask : send_byte
  // ack_it low gives the closing nack before stop
  task automatic recv_byte(output logic [7:0] d, input logic ack_it);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(~ack_it);
  endtask : recv_byte
  // callers keep counts at most 32, set pointers first, stay in range
  task automatic write_msg(input logic [7:0] q[$], output logic acked);
    logic a;
    bus_start();
    acked = 1'b1;
    foreach (q[i]) begin
      send_byte(q[i], a);
      acked = acked & a;
    end
    bus_stop();
  endtask : write_msg
endmodule : srea_master

// ===== test/srea_top_tb.sv
// self-checking bench for the smbus ram/eeprom access block
`timescale 1ns/10ps
module srea_top_tb;
  localparam logic [7:0] WR_ADDR = 8'h98;
  localparam logic [7:0] RD_ADDR = 8'h99;
  logic ref_clk, sys_rst, pin_hi, pin_lo, m_scl_low, m_sda_low;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, ee_prog, ee_erase, busy;
  logic [9:0] ee_rd_addr, ee_prog_addr;
  logic [7:0] ee_wdata, ee_rdata;
  logic [4:0] ee_erase_page;
  logic [7:0] ee_mem [0:1023];
  logic [7:0] ram_exp [0:255];
  int mismatches = 0, samples_checked = 0, prog_cnt = 0, erase_cnt = 0, stretch_cnt = 0;
  // open-drain wires: anyone pulling low wins, pull-up otherwise
  wire scl = ~m_scl_low & (scl_oe_n | scl_out);
  wire sda = ~m_sda_low & (sda_oe_n | sda_out);
  assign ee_rdata = ee_mem[ee_rd_addr];
  srea_top #(.PROG_CYCLES(200), .ERASE_CYCLES(400)) i_srea_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_hi_pin(pin_hi), .addr_select_lo_pin(pin_lo), .ee_rdata(ee_rdata),
    .ee_rd_addr(ee_rd_addr), .ee_prog(ee_prog), .ee_prog_addr(ee_prog_addr),
    .ee_wdata(ee_wdata), .ee_erase(ee_erase), .ee_erase_page(ee_erase_page), .busy(busy));
  srea_master i_srea_master (.ref_clk(ref_clk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // eeprom array model plus pulse and stretch counters
  always @(posedge ref_clk) begin
    if (ee_prog === 1'b1) begin
      ee_mem[ee_prog_addr] <= ee_wdata;
      prog_cnt <= prog_cnt + 1;
    end
    if (ee_erase === 1'b1) begin
      erase_cnt <= erase_cnt + 1;
      for (int j = 0; j < 32; j++) ee_mem[{ee_erase_page, 5'(j)}] <= 8'hFF;
    end
    if (scl_oe_n === 1'b0) stretch_cnt <= stretch_cnt + 1;
  end
  task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flag
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction : crc8
  // bounded wait; a hang here is cut by the watchdog anyway
  task automatic wait_idle;
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge ref_clk);
  endtask : wait_idle
  task automatic rd_one(output logic [7:0] d);
    logic a;
    i_srea_master.bus_start();
    i_srea_master.send_byte(RD_ADDR, a);
    i_srea_master.recv_byte(d, 1'b0);
    i_srea_master.bus_stop();
  endtask : rd_one
  task automatic t_pins;
    logic a;
    for (int p = 0; p < 4; p++) begin
      @(negedge ref_clk);
      {pin_hi, pin_lo} = 2'(p);
      repeat (4) @(negedge ref_clk);
      i_srea_master.write_msg('{{5'h13, 2'(p ^ 1), 1'b0}, 8'h00}, a);
      check_flag(a, 1'b0);
      i_srea_master.write_msg('{{5'h13, 2'(p), 1'b0}, 8'h00}, a);
      check_flag(a, 1'b1);
    end
    @(negedge ref_clk);
    {pin_hi, pin_lo} = 2'h0;
    repeat (4) @(negedge ref_clk);
  endtask : t_pins
  // both ends of the ram range, read back through the pointer
  task automatic t_ram;
    logic [7:0] cmd [3] = '{8'h00, 8'hDF, 8'h10};
    logic [7:0] dat [3] = '{8'h11, 8'h22, 8'h5A};
    logic a;
    logic [7:0] d;
    for (int k = 0; k < 3; k++) begin
      i_srea_master.write_msg('{WR_ADDR, cmd[k], dat[k]}, a);
      check_flag(a, 1'b1);
      ram_exp[cmd[k]] = dat[k];
    end
    for (int k = 0; k < 3; k++) begin
      i_srea_master.write_msg('{WR_ADDR, cmd[k]}, a);
      rd_one(d);
      check_val({2'h0, d}, {2'h0, dat[k]});
    end
  endtask : t_ram
  task automatic t_ee;
    logic a;
    logic [7:0] d;
    i_srea_master.write_msg('{WR_ADDR, 8'hF9, 8'h23, 8'hAB}, a);
    check_val(10'(prog_cnt), 10'h001);
    check_val(ee_prog_addr, 10'h123);
    check_val({2'h0, ee_wdata}, 10'h0AB);
    check_flag(busy, 1'b1);
    wait_idle();
    i_srea_master.write_msg('{WR_ADDR, 8'hF9, 8'h23}, a);
    rd_one(d);
    check_val(ee_rd_addr, 10'h123);
    check_val({2'h0, d}, 10'h0AB);
  endtask : t_ee
  // back-to-back block bytes must stretch while the byte ahead of them programs
  task automatic t_blk_ee;
    logic a;
    int s0, n0;
    wait_idle();
    i_srea_master.write_msg('{WR_ADDR, 8'hF8, 8'h1E}, a);
    s0 = stretch_cnt;
    n0 = prog_cnt;
    i_srea_master.write_msg('{WR_ADDR, 8'hFC, 8'h03, 8'hD1, 8'hD2, 8'hD3}, a);
    check_flag(a, 1'b1);
    check_flag(stretch_cnt - s0 > 100, 1'b1);
    wait_idle();
    check_val(10'(prog_cnt - n0), 10'h003);
    for (int k = 0; k < 3; k++) check_val({2'h0, ee_mem[10'h01E + k]}, 10'(10'h0D1 + k));
  endtask : t_blk_ee
  task automatic t_blk_rd;
    logic a;
    logic [7:0] d, crc;
    i_srea_master.write_msg('{WR_ADDR, 8'h01}, a);
    // the byte beyond the count is a check byte; ram[3] must stay clear
    i_srea_master.write_msg('{WR_ADDR, 8'hFC, 8'h02, 8'h33, 8'h44, 8'hA5}, a);
    check_flag(a, 1'b1);
    ram_exp[1] = 8'h33;
    ram_exp[2] = 8'h44;
    i_srea_master.write_msg('{WR_ADDR, 8'h00}, a);
    i_srea_master.bus_start();
    i_srea_master.send_byte(WR_ADDR, a);
    i_srea_master.send_byte(8'hFD, a);
    i_srea_master.bus_start();
    i_srea_master.send_byte(RD_ADDR, a);
    check_flag(a, 1'b1);
    crc = crc8(crc8(crc8(crc8(8'h00, WR_ADDR), 8'hFD), RD_ADDR), 8'h20);
    i_srea_master.recv_byte(d, 1'b1);
    check_val({2'h0, d}, 10'h020);
    for (int k = 0; k < 32; k++) begin
      i_srea_master.recv_byte(d, 1'b1);
      check_val({2'h0, d}, {2'h0, ram_exp[k]});
      crc = crc8(crc, ram_exp[k]);
    end
    i_srea_master.recv_byte(d, 1'b0);
    check_val({2'h0, d}, {2'h0, crc});
    i_srea_master.bus_stop();
  endtask : t_blk_rd
  // refused with the enable clear, then busy nacks until done
  task automatic t_erase;
    logic a;
    int e0;
    wait_idle();
    e0 = erase_cnt;
    i_srea_master.write_msg('{WR_ADDR, 8'hF9, 8'h65}, a);
    i_srea_master.write_msg('{WR_ADDR, 8'hFE}, a);
    repeat (10) @(negedge ref_clk);
    check_val(10'(erase_cnt - e0), 10'h000);
    i_srea_master.write_msg('{WR_ADDR, 8'h90, 8'h04}, a);
    i_srea_master.write_msg('{WR_ADDR, 8'hF9, 8'h65}, a);
    i_srea_master.write_msg('{WR_ADDR, 8'hFE}, a);
    check_val(10'(erase_cnt - e0), 10'h001);
    check_val({5'h00, ee_erase_page}, 10'h00B);
    i_srea_master.write_msg('{WR_ADDR, 8'h00}, a);
    check_flag(a, 1'b0);
    wait_idle();
    i_srea_master.write_msg('{WR_ADDR, 8'h00}, a);
    check_flag(a, 1'b1);
  endtask : t_erase
  initial begin
    sys_rst = 1'b1;
    pin_hi = 1'b0;
    pin_lo = 1'b0;
    foreach (ee_mem[i]) ee_mem[i] = 8'hFF;
    foreach (ram_exp[i]) ram_exp[i] = 8'h00;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    t_pins();
    t_ram();
    t_ee();
    t_blk_ee();
    t_blk_rd();
    t_erase();
    final_report();
  end
  // whole sequence needs well under a millisecond of bus time
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
endmodule : srea_top_tb
